// ==== hdl/mhc_top.sv ====
// Host control, status stack and port service engine of the mux
`timescale 1ns/1ps
module mhc_top import mhc_pkg::*; #(
  parameter int RTC_CYC  = RTC_CYC_DEF,
  parameter int SCAN_CYC = SCAN_CYC_DEF
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  input  wire logic         bus_io_reset,
  output mhc_mem_req_s      mem_req,
  input  wire logic         mem_ack,
  input  wire logic [15:0]  mem_rdata,
  input  wire mhc_rx_evt_s  rx_evt,
  output logic              rx_ready,
  input  wire logic [127:0] port_tx_free,
  input  wire logic [127:0] port_dev_status,
  output mhc_tx_s           tx_out,
  output mhc_fx_s           reset_fx,
  output logic              busy_flag,
  output logic              done_flag
);

  mhc_state_s q;
  mhc_state_s n;

  // Word address of a control block entry
  function automatic logic [14:0] cwa(logic [15:0] b, logic [6:0] p, logic [2:0] w);
    cwa = b[14:0] + {5'h00, p, w};
  endfunction

  function automatic mhc_mem_req_s mrd(logic [14:0] a);
    mrd = '{req: 1'b1, we: 1'b0, addr: a, wdata: '0};
  endfunction

  function automatic mhc_mem_req_s mwr(logic [14:0] a, logic [15:0] d);
    mwr = '{req: 1'b1, we: 1'b1, addr: a, wdata: d};
  endfunction

  // Format the top stack entry as a status word
  function automatic logic [15:0] sword(mhc_ent_s e, logic ovf, logic empty);
    sword = '0;
    if (!empty) begin
      sword[SW_RTI]              = e.rti;
      sword[SW_OVF]              = ovf;
      sword[SW_PID]              = e.pid;
      sword[SW_POD]              = e.pod;
      sword[SW_ID_H -: 7]        = e.port;
    end
  endfunction

  logic       push;
  logic       pop;
  logic       clr;
  logic       full_rst;
  logic       ack;
  logic       acc;
  logic       spec;
  logic [7:0] b;
  mhc_ent_s   ent;

  // Next state of the whole block
  always_comb begin
    n = q;
    push = 1'b0;
    pop = 1'b0;
    clr = 1'b0;
    full_rst = bus_io_reset;
    ent = '0;
    spec = 1'b0;
    b = '0;
    ack = q.mem.req && mem_ack;
    acc = psel && penable;
    n.tx.valid = 1'b0;
    n.fx.lines_idle = 1'b0;
    n.fx.ctl_all = 1'b0;
    n.fx.defaults = 1'b0;
    n.fx.baud = BAUD_110;
    n.fx.port0_cfg = PORT0_CFG;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // Timers: 100 Hz tick and idle output scan
    if (q.rtc) begin
      if (q.rtc_cnt == CNT_W'(RTC_CYC - 1)) begin
        n.rtc_cnt = '0;
        n.rtc_pend = 1'b1;
      end else begin
        n.rtc_cnt = q.rtc_cnt + 1'b1;
      end
    end
    if (q.busy) begin
      if (q.scan_cnt == CNT_W'(SCAN_CYC - 1)) begin
        n.scan_cnt = '0;
        n.scan_pend = 1'b1;
      end else begin
        n.scan_cnt = q.scan_cnt + 1'b1;
      end
    end

    // APB: first access cycle answers, second commits
    if (acc && !q.pready) begin
      n.pready = 1'b1;
      n.prdata = '0;
      unique case (paddr)
        A_CMD:     n.prdata = {22'h00_0000, q.cnt, q.ovf, q.rtc, q.done, q.busy};
        A_DOA:     n.pslverr = !pwrite;
        A_STAT,
        A_STATPOP: begin
          n.prdata = {16'h0000, sword(mhc_ent_s'(q.stk[0]), q.ovf, q.cnt == '0)};
          n.pslverr = pwrite;
        end
        A_BASE: begin
          n.prdata = {16'h0000, q.base};
          n.pslverr = pwrite;
        end
        default:   n.pslverr = 1'b1;
      endcase
      if (paddr == A_CMD) begin
        n.pslverr = 1'b0;
      end
    end
    if (acc && q.pready && !q.pslverr) begin
      if (pwrite && paddr == A_CMD) begin
        clr = pwdata[C_CLR];
        if (pwdata[C_CLK]) begin
          n.rtc = 1'b1;
        end
        pop = pwdata[C_START];
        if (pwdata[C_RESUME]) begin
          n.busy = 1'b1;
          n.scan_pend = 1'b1;
          n.scan_port = '0;
        end
        if (pwdata[C_PAUSE]) begin
          n.busy = 1'b0;
        end
      end else if (pwrite && paddr == A_DOA) begin
        if (!q.busy) begin
          n.base = pwdata[15:0] & BASE_MASK;
        end else begin
          n.scan_pend = 1'b1;
          n.scan_port = '0;
        end
      end else if (!pwrite && (paddr == A_STAT || paddr == A_STATPOP)) begin
        if (q.cnt != '0) begin
          n.stk[0][9] = 1'b0;
        end
        pop = (paddr == A_STATPOP);
      end
    end

    // Port service engine; a pause waits for the port to end
    unique case (q.st)
      S_IDLE: begin
        if (q.busy && rx_evt.valid && q.rx_rdy) begin
          n.rx = 1'b1;
          n.port = rx_evt.port;
          n.ch = rx_evt.data;
          n.err = rx_evt.err;
          n.st = S_RDCW;
          n.mem = mrd(cwa(q.base, rx_evt.port, W_ICW));
        end else if (q.busy && q.scan_pend) begin
          n.scan_port = q.scan_port + 1'b1;
          if (q.scan_port == 7'h7F) begin
            n.scan_pend = 1'b0;
          end
          if (port_tx_free[q.scan_port]) begin
            n.rx = 1'b0;
            n.port = q.scan_port;
            n.dstat = port_dev_status[q.scan_port];
            n.st = S_RDCW;
            n.mem = mrd(cwa(q.base, q.scan_port, W_OCW));
          end
        end
      end
      S_RDCW: if (ack) begin
        n.cw = mem_rdata;
        n.irq = 1'b0;
        n.mem.req = 1'b0;
        if (q.rx) begin
          if (!mem_rdata[B_AUTO]) begin
            n.cw[B_DONE] = 1'b1;
            n.cw[7:0] = q.ch;
            n.irq = 1'b1;
            n.st = S_WRCW;
            n.mem = mwr(cwa(q.base, q.port, W_ICW), n.cw);
          end else begin
            n.efail = mem_rdata[B_ECHO] && !port_tx_free[q.port];
            n.st = S_RDPTR;
            n.mem = mrd(cwa(q.base, q.port, W_IPTR));
          end
        end else begin
          n.cw[B_PDS] = mem_rdata[B_DSTAT];
          if (mem_rdata[B_DONE] || mem_rdata[B_MODE_H -: 2] == OM_OFF) begin
            n.st = S_IDLE;
          end else if (mem_rdata[B_MODE_H -: 2] == OM_AUTO) begin
            if (mem_rdata[B_DSTAT] != q.dstat) begin
              n.cw[B_DONE] = 1'b1;
              n.cw[B_DSC] = 1'b1;
              n.irq = 1'b1;
              n.st = S_WRCW;
              n.mem = mwr(cwa(q.base, q.port, W_OCW), n.cw);
            end else begin
              n.st = S_RDPTR;
              n.mem = mrd(cwa(q.base, q.port, W_OPTR));
            end
          end else begin
            // Port control or single char: send now, done written at once
            n.tx = '{valid: 1'b1, port: q.port, data: mem_rdata[7:0],
                     ctrl: mem_rdata[B_MODE_H -: 2] == OM_PORT_SETUP_OUTPUT,
                     dctl: mem_rdata[B_OPT]};
            n.cw[B_DONE] = 1'b1;
            n.irq = 1'b1;
            n.st = S_WRCW;
            n.mem = mwr(cwa(q.base, q.port, W_OCW), n.cw);
          end
        end
      end
      S_RDPTR: if (ack) begin
        n.ptr = mem_rdata + 1'b1;
        n.st = S_RDLAST;
        n.mem = mrd(cwa(q.base, q.port, q.rx ? W_ILAST : W_OLAST));
      end
      S_RDLAST: if (ack) begin
        n.last = mem_rdata;
        if (q.rx && !q.ptr[0] && q.ptr != mem_rdata) begin
          n.st = S_WRBUF;  // Left byte fills both halves
          n.mem = mwr(q.ptr[15:1], {q.ch, q.ch});
        end else begin
          n.st = S_RDBUF;
          n.mem = mrd(q.ptr[15:1]);
        end
      end
      S_RDBUF: if (ack) begin
        if (q.rx) begin
          n.st = S_WRBUF;
          n.mem = mwr(q.ptr[15:1], q.ptr[0] ? {mem_rdata[15:8], q.ch}
                                             : {q.ch, mem_rdata[7:0]});
        end else begin
          b = q.ptr[0] ? mem_rdata[7:0] : mem_rdata[15:8];
          if (q.cw[B_OPT] && b <= SPECIAL_MAX) begin
            n.cw[B_DONE] = 1'b1;
            n.cw[B_DSC] = 1'b1;
            n.cw[7:0] = b;
            n.irq = 1'b1;
            n.st = S_WRCW;
            n.mem = mwr(cwa(q.base, q.port, W_OCW), n.cw);
          end else begin
            n.tx = '{valid: 1'b1, port: q.port, data: b, ctrl: 1'b0, dctl: 1'b0};
            n.st = S_WRPTR;
            n.mem = mwr(cwa(q.base, q.port, W_OPTR), q.ptr);
          end
        end
      end
      S_WRBUF: if (ack) begin
        n.st = S_WRPTR;
        n.mem = mwr(cwa(q.base, q.port, W_IPTR), q.ptr);
      end
      S_WRPTR: if (ack) begin
        if (q.rx) begin
          spec = q.cw[B_OPT] && q.ch <= SPECIAL_MAX;
          if (q.cw[B_ECHO] && !q.efail) begin
            n.tx = '{valid: 1'b1, port: q.port, data: q.ch, ctrl: 1'b0, dctl: 1'b0};
          end
          if (q.ptr >= q.last || spec || q.err != 2'h0 || q.efail) begin
            n.cw[B_DONE] = 1'b1;
            n.cw[B_ERR_H -: 2] = q.err;
            n.cw[B_EFAIL] = q.efail;
            if (spec) begin
              n.cw[7:0] = q.ch;
            end
            n.irq = 1'b1;
            n.st = S_WRCW;
            n.mem = mwr(cwa(q.base, q.port, W_ICW), n.cw);
          end else begin
            n.st = S_IDLE;
            n.mem.req = 1'b0;
          end
        end else begin
          if (q.ptr >= q.last) begin
            n.cw[B_DONE] = 1'b1;
            n.irq = 1'b1;
          end
          n.st = S_WRCW;
          n.mem = mwr(cwa(q.base, q.port, W_OCW), n.cw);
        end
      end
      S_WRCW: if (ack) begin
        n.st = S_IDLE;
        n.mem.req = 1'b0;
        push = q.irq;
        ent = '{rti: 1'b0, pid: q.rx, pod: !q.rx, port: q.port};
      end
    endcase

    // Reset and clear override all above
    if (clr || full_rst) begin
      n.busy = 1'b0;
      n.rtc = 1'b0;
      n.rtc_cnt = '0;
      n.scan_pend = 1'b0;
      n.st = S_IDLE;
      n.mem.req = 1'b0;
      n.tx.valid = 1'b0;
      n.fx.lines_idle = 1'b1;
      push = 1'b0;
      pop = 1'b0;
    end
    if (full_rst) begin
      n.fx.ctl_all = 1'b1;
      n.fx.defaults = 1'b1;
      n.base = BASE_DEF;
    end

    // Status stack: pop, then engine entry, else tick entry
    if (clr || full_rst) begin
      n.cnt = '0;
      n.ovf = 1'b0;
      n.rtc_pend = 1'b0;
    end else begin
      if (pop) begin
        if (n.ovf) begin
          n.cnt = '0;
          n.ovf = 1'b0;
        end else if (n.cnt != '0) begin
          for (int i = 0; i < STK_DEPTH - 1; i++) begin
            n.stk[i] = n.stk[i+1];
          end
          n.cnt = n.cnt - 1'b1;
        end
      end
      if (!push && n.rtc_pend) begin
        push = 1'b1;
        ent = '{rti: 1'b1, pid: 1'b0, pod: 1'b0, port: 7'h00};
        n.rtc_pend = 1'b0;
      end
      if (push && !n.ovf) begin
        n.stk[n.cnt] = ent;
        n.cnt = n.cnt + 1'b1;
        if (n.cnt == STK_FULL) begin
          n.ovf = 1'b1;
        end
      end
    end
    n.done = (n.cnt != '0);
    n.rx_rdy = (n.st == S_IDLE) && n.busy && !(q.st == S_IDLE && n.st != S_IDLE);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: S_IDLE, base: BASE_DEF, default: '0};
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign prdata    = q.prdata;
  assign mem_req   = q.mem;
  assign rx_ready  = q.rx_rdy;
  assign tx_out    = q.tx;
  assign reset_fx  = q.fx;
  assign busy_flag = q.busy;
  assign done_flag = q.done;

endmodule

// ==== inc/mhc_pkg.sv ====
// Shared constants and carrier types for the mux host control block
package mhc_pkg;
  // Clock and timing
  localparam int CLK_NS       = 8;
  localparam int RTC_NS       = 10_000_000;  // 100 Hz tick period
  localparam int SCAN_NS      = 50_000_000;  // Idle output scan period
  localparam int RTC_CYC_DEF  = (RTC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCAN_CYC_DEF = (SCAN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 24;
  // Status stack
  localparam int          STK_DEPTH = 40;
  localparam logic [5:0]  STK_FULL  = 6'(STK_DEPTH);
  // Control block area
  localparam logic [15:0] BASE_DEF  = 16'h3C00;  // 36000 octal
  localparam logic [15:0] BASE_MASK = 16'hFF00;  // Eight msb only
  // APB byte offsets
  localparam logic [7:0] A_CMD     = 8'h00;
  localparam logic [7:0] A_DOA     = 8'h04;
  localparam logic [7:0] A_STAT    = 8'h08;
  localparam logic [7:0] A_STATPOP = 8'h0C;
  localparam logic [7:0] A_BASE    = 8'h10;
  // Command register bits
  localparam int C_CLR    = 0;
  localparam int C_CLK    = 1;
  localparam int C_START  = 2;
  localparam int C_RESUME = 3;
  localparam int C_PAUSE  = 4;
  // Word offsets within a port control block
  localparam logic [2:0] W_ICW   = 3'h0;
  localparam logic [2:0] W_OCW   = 3'h1;
  localparam logic [2:0] W_IPTR  = 3'h4;
  localparam logic [2:0] W_OPTR  = 3'h5;
  localparam logic [2:0] W_ILAST = 3'h6;
  localparam logic [2:0] W_OLAST = 3'h7;
  // Control word bits (bit 15 is the msb)
  localparam int B_DONE  = 15;
  localparam int B_AUTO  = 14;
  localparam int B_ECHO  = 13;
  localparam int B_OPT   = 12;
  localparam int B_DSTAT = 11;
  localparam int B_PDS   = 10;
  localparam int B_EFAIL = 9;
  localparam int B_DSC   = 8;
  localparam int B_ERR_H = 11;
  localparam int B_MODE_H = 14;
  localparam logic [1:0] OM_OFF  = 2'h0;
  localparam logic [1:0] OM_AUTO = 2'h1;
  localparam logic [1:0] OM_PORT_SETUP_OUTPUT = 2'h2;
  // Special characters are control codes up to this value
  localparam logic [7:0] SPECIAL_MAX = 8'h1F;
  // Full reset defaults
  localparam logic [2:0] BAUD_110  = 3'h0;
  localparam logic [7:0] PORT0_CFG = 8'hF0;  // 8 bits, no parity, 2 stop
  // Status word bits
  localparam int SW_RTI  = 15;
  localparam int SW_OVF  = 14;
  localparam int SW_PID  = 13;
  localparam int SW_POD  = 12;
  localparam int SW_ID_H = 11;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_RDCW   = 3'b001,
    S_RDPTR  = 3'b011,
    S_RDLAST = 3'b010,
    S_RDBUF  = 3'b110,
    S_WRBUF  = 3'b111,
    S_WRPTR  = 3'b101,
    S_WRCW   = 3'b100
  } mhc_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [14:0] addr;
    logic [15:0] wdata;
  } mhc_mem_req_s;

  typedef struct packed {
    logic       valid;
    logic [6:0] port;
    logic [7:0] data;
    logic [1:0] err;
  } mhc_rx_evt_s;

  typedef struct packed {
    logic       valid;
    logic [6:0] port;
    logic [7:0] data;
    logic       ctrl;
    logic       dctl;
  } mhc_tx_s;

  typedef struct packed {
    logic       lines_idle;
    logic       ctl_all;
    logic       defaults;
    logic [2:0] baud;
    logic [7:0] port0_cfg;
  } mhc_fx_s;

  typedef struct packed {
    logic       rti;
    logic       pid;
    logic       pod;
    logic [6:0] port;
  } mhc_ent_s;

  typedef struct packed {
    mhc_state_e                  st;
    logic [6:0]                  port;
    logic                        rx;
    logic [7:0]                  ch;
    logic [1:0]                  err;
    logic                        dstat;
    logic                        efail;
    logic                        irq;
    logic [15:0]                 cw;
    logic [15:0]                 ptr;
    logic [15:0]                 last;
    mhc_mem_req_s                mem;
    mhc_tx_s                     tx;
    mhc_fx_s                     fx;
    logic                        rx_rdy;
    logic                        busy;
    logic                        done;
    logic                        rtc;
    logic                        rtc_pend;
    logic [CNT_W-1:0]            rtc_cnt;
    logic [CNT_W-1:0]            scan_cnt;
    logic                        scan_pend;
    logic [6:0]                  scan_port;
    logic [15:0]                 base;
    logic [STK_DEPTH-1:0][9:0]   stk;
    logic [5:0]                  cnt;
    logic                        ovf;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
  } mhc_state_s;
endpackage

// ==== verif/mhc_mem_model.sv ====
// Data channel memory model answering the engine's word requests
`timescale 1ns/1ps
module mhc_mem_model import mhc_pkg::*; (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire mhc_mem_req_s mem_req,
  output logic              mem_ack,
  output logic [15:0]       mem_rdata
);
  logic [15:0] mem [0:32767];
  logic [15:0] noise;
  int          wait_n;

  // Cleared core: idle words read inactive
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // Read data only while acknowledging
  assign mem_rdata = mem_ack ? mem[mem_req.addr] : noise;

  // Ack each held request after 0 to 2 wait cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_n  <= 0;
      noise   <= 16'h5a3c;
    end else begin
      noise <= noise + 16'h3d5b;
      if (mem_ack) begin
        mem_ack <= 1'b0;
        if (mem_req.req && mem_req.we) begin
          mem[mem_req.addr] <= mem_req.wdata;
        end
      end else if (mem_req.req) begin
        if (wait_n == 0) begin
          mem_ack <= 1'b1;
          wait_n  <= $urandom_range(2, 0);
        end else begin
          wait_n <= wait_n - 1;
        end
      end
    end
  end
endmodule

// ==== verif/mhc_properties.sv ====
// Concurrent port checks for the mux host control block
`timescale 1ns/1ps
module mhc_properties import mhc_pkg::*; (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          bus_io_reset,
  input wire mhc_mem_req_s  mem_req,
  input wire mhc_rx_evt_s   rx_evt,
  input wire logic          rx_ready,
  input wire mhc_tx_s       tx_out,
  input wire mhc_fx_s       reset_fx,
  input wire logic          busy_flag,
  input wire logic          done_flag
);
  logic       cmd_wr;
  logic       rx_take;
  logic       stop_pend;
  logic [7:0] rx_ch_q;

  default clocking cb_def @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Command write taken, character taken
  assign cmd_wr  = psel && penable && pready && pwrite && (paddr == A_CMD);
  assign rx_take = rx_evt.valid && rx_ready;

  // Stopped since last resume; last char taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_pend <= 1'b1;
      rx_ch_q   <= 8'h00;
    end else begin
      if (bus_io_reset || (cmd_wr && (pwdata[C_CLR] || pwdata[C_PAUSE]))) begin
        stop_pend <= 1'b1;
      end else if (cmd_wr && pwdata[C_RESUME]) begin
        stop_pend <= 1'b0;
      end
      if (rx_take) begin
        rx_ch_q <= rx_evt.data;
      end
    end
  end

  property p_io_flags;
    bus_io_reset |=> !busy_flag && !done_flag;
  endproperty
  a_io_flags: assert property (p_io_flags) else $error("flags not cleared by reset");
  property p_io_fx;
    bus_io_reset |-> ##[1:2] (reset_fx.lines_idle && reset_fx.ctl_all && reset_fx.defaults);
  endproperty
  a_io_fx: assert property (p_io_fx) else $error("full reset effects missing");
  property p_clr_idle;
    cmd_wr && pwdata[C_CLR] && !bus_io_reset |-> ##[1:2] reset_fx.lines_idle;
  endproperty
  a_clr_idle: assert property (p_clr_idle) else $error("clear left lines active");
  property p_clr_keep;
    cmd_wr && pwdata[C_CLR] && !bus_io_reset |=>
      (!reset_fx.ctl_all && !reset_fx.defaults)[*2];
  endproperty
  a_clr_keep: assert property (p_clr_keep) else $error("clear applied reset extras");
  property p_clk_only;
    cmd_wr && (pwdata[4:0] == 5'b00010) && !bus_io_reset |=> $stable(busy_flag);
  endproperty
  a_clk_only: assert property (p_clk_only) else $error("clock start moved busy");
  property p_resume;
    cmd_wr && pwdata[C_RESUME] && !pwdata[C_CLR] && !pwdata[C_PAUSE] && !bus_io_reset
      |=> busy_flag;
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not set busy");
  property p_busy_hold;
    $fell(busy_flag) |-> stop_pend;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped without stop");
  property p_pause;
    cmd_wr && pwdata[C_PAUSE] |-> ##[0:40] !mem_req.req;
  endproperty
  a_pause: assert property (p_pause) else $error("transfers continue after pause");
  property p_pause_hold;
    stop_pend && !mem_req.req |=> !mem_req.req;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("request while paused");
  property p_out_done;
    tx_out.valid |-> ##[0:4] (mem_req.req && mem_req.we && mem_req.wdata[B_DONE]);
  endproperty
  a_out_done: assert property (p_out_done) else $error("no done write for output");
  property p_rx_store;
    rx_take |=> ##[0:60] (mem_req.req && mem_req.we && (mem_req.wdata[7:0] == rx_ch_q));
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("received char not stored");
endmodule

bind mhc_top mhc_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .bus_io_reset(bus_io_reset),
  .mem_req(mem_req), .rx_evt(rx_evt), .rx_ready(rx_ready), .tx_out(tx_out),
  .reset_fx(reset_fx), .busy_flag(busy_flag), .done_flag(done_flag)
);

// ==== verif/tb_mux_host_control_and_port_service.sv ====
// Self-checking bench for the mux host control block
`timescale 1ns/1ps
module tb_mux_host_control_and_port_service import mhc_pkg::*; ;
  typedef struct packed {
    logic [32:0] val;
    logic [32:0] msk;
  } mhc_exp_s;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_io_reset;
  logic         mem_ack, rx_ready, busy_flag, done_flag;
  logic [7:0]   paddr, cb, ch1, ch2;
  logic [31:0]  pwdata, prdata, rnd;
  logic [15:0]  mem_rdata, base;
  logic [127:0] port_tx_free, port_dev_status;
  logic [6:0]   pa, pb, pc;
  mhc_mem_req_s mem_req;
  mhc_rx_evt_s  rx_evt;
  mhc_tx_s      tx_out;
  mhc_fx_s      reset_fx;
  mhc_exp_s     apb_q[$];
  mhc_exp_s     e;
  logic [15:0]  tx_q[$];
  int           fails, samples_checked, n;

  mhc_top #(.RTC_CYC(50), .SCAN_CYC(3000)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .bus_io_reset(bus_io_reset), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rx_evt(rx_evt), .rx_ready(rx_ready),
    .port_tx_free(port_tx_free), .port_dev_status(port_dev_status), .tx_out(tx_out),
    .reset_fx(reset_fx), .busy_flag(busy_flag), .done_flag(done_flag)
  );
  mhc_mem_model mem_u (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // Free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    chk(33'(apb_q.size() + tx_q.size()), 33'h0);
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer, answer noted
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] ev, input logic [32:0] em);
    apb_q.push_back('{ev, em});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] em);
    apb(1'b0, a, 32'h0, {1'b0, ev}, {1'b1, em});
  endtask

  function automatic logic [14:0] cw_addr(input logic [6:0] p, input logic [2:0] w);
    return base[14:0] + {5'b0, p, w};
  endfunction

  task automatic mw(input logic [6:0] p, input logic [2:0] w, input logic [15:0] ev,
                    input logic [15:0] em);
    chk({17'h0, mem_u.mem[cw_addr(p, w)] & em}, {17'h0, ev & em});
  endtask

  // One received character
  task automatic rx(input logic [6:0] p, input logic [7:0] c);
    rx_evt <= '{1'b1, p, c, 2'b00};
    do @(posedge pclk); while (rx_ready !== 1'b1);
    rx_evt <= '{1'b0, ~p, ~c, 2'b11};
    @(posedge pclk);
  endtask

  task automatic io_rst();
    bus_io_reset <= 1'b1;
    @(posedge pclk);
    bus_io_reset <= 1'b0;
    @(posedge pclk);
  endtask

  // APB answers against the oldest note
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready === 1'b1) begin
      e = (apb_q.size() != 0) ? apb_q.pop_front() : '{33'h0, 33'h1_ffff_ffff};
      chk({pslverr, prdata} & e.msk, e.val & e.msk);
    end
  end

  // Port characters against the oldest note
  always @(posedge pclk) begin
    if (presetn && tx_out.valid === 1'b1) begin
      chk({17'h0, tx_out.port, tx_out.data, tx_out.ctrl},
          {17'h0, (tx_q.size() != 0) ? tx_q.pop_front() : 16'hffff});
    end
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    summarize();
  end

  initial begin
    void'($urandom(59418));
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 8'h00;
    pwdata          = 32'h0000_0000;
    bus_io_reset    = 1'b0;
    rx_evt          = '0;
    port_tx_free    = '1;
    port_dev_status = '0;
    fails           = 0;
    samples_checked = 0;
    base            = BASE_DEF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state, refused accesses
    rd(A_BASE, {16'h0, BASE_DEF}, 32'h0000_ffff);
    rd(A_CMD, 32'h0, 32'h0000_000f);
    apb(1'b0, 8'h14, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
    apb(1'b1, A_STAT, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    apb(1'b0, A_DOA, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    // Base load, clear and full reset
    rnd = $urandom();
    wr(A_DOA, rnd);
    base = {rnd[15:8], 8'h00};
    rd(A_BASE, {16'h0, base}, 32'h0000_ffff);
    wr(A_CMD, 32'h0000_0001 << C_CLR);
    rd(A_BASE, {16'h0, base}, 32'h0000_ffff);
    io_rst();
    rd(A_BASE, {16'h0, BASE_DEF}, 32'h0000_ffff);
    rnd = $urandom();
    wr(A_DOA, rnd);
    base = {rnd[15:8], 8'h00};
    // Clock ticks, overflow and flush
    wr(A_CMD, 32'h0000_0001 << C_CLK);
    rd(A_CMD, 32'h0000_0004, 32'h0000_0005);
    repeat (60) @(posedge pclk);
    rd(A_STAT, 32'h0000_8000, 32'h0000_f01f);
    rd(A_STAT, 32'h0000_0000, 32'h0000_8000);
    wr(A_CMD, 32'h0000_0001 << C_START);
    repeat (2100) @(posedge pclk);
    rd(A_CMD, {22'h0, 6'd40, 4'b1110}, 32'h0000_03ff);
    rd(A_STAT, 32'h0000_4000, 32'h0000_4000);
    wr(A_CMD, 32'h0000_0001 << C_START);
    rd(A_CMD, 32'h0000_0004, 32'h0000_03ec);
    wr(A_CMD, 32'h0000_0001 << C_CLR);
    rd(A_CMD, 32'h0, 32'h0000_03ff);
    // Port control and single output
    pb  = 7'(1 + $urandom_range(60));
    pa  = 7'(64 + $urandom_range(60));
    pc  = 7'($urandom_range(127));
    cb  = 8'($urandom());
    ch1 = 8'($urandom());
    ch2 = 8'($urandom());
    mem_u.mem[cw_addr(pb, W_OCW)] = 16'h4000 | {8'h00, cb};
    mem_u.mem[cw_addr(pa, W_OCW)] = 16'h6000 | {8'h00, ch1};
    tx_q.push_back({pb, cb, 1'b1});
    tx_q.push_back({pa, ch1, 1'b0});
    wr(A_CMD, 32'h0000_0001 << C_RESUME);
    rd(A_CMD, 32'h0000_0001, 32'h0000_0001);
    for (n = 0; n < 3000 && tx_q.size() != 0; n++) @(posedge pclk);
    repeat (12) @(posedge pclk);
    mw(pb, W_OCW, 16'h8000, 16'h8000);
    mw(pa, W_OCW, 16'h8000, 16'h8000);
    rd(A_CMD, 32'h0000_0003, 32'h0000_0003);
    wr(A_CMD, 32'h0000_0001 << C_PAUSE);
    rd(A_STATPOP, {16'h0, 4'b0001, pb, 5'b0}, 32'h0000_ffff);
    rd(A_STATPOP, {16'h0, 4'b0001, pa, 5'b0}, 32'h0000_ffff);
    rd(A_CMD, 32'h0, 32'h0000_0003);
    wr(A_CMD, 32'h0000_0001 << C_RESUME);
    // Single character input
    rx(pc, ch2);
    for (n = 0; n < 400 && done_flag !== 1'b1; n++) @(posedge pclk);
    mw(pc, W_ICW, {8'h80, ch2}, 16'h80ff);
    wr(A_CMD, 32'h0000_0001 << C_PAUSE);
    rd(A_STATPOP, {16'h0, 4'b0010, pc, 5'b0}, 32'h0000_ffff);
    wr(A_CMD, 32'h0000_0001 << C_RESUME);
    io_rst();
    rd(A_CMD, 32'h0, 32'h0000_000f);
    summarize();
  end
endmodule
